// File: hw/ref_clock_pkg.sv
/*
 * shared constants and carrier types for the serializer reference-clock select block.
 * assumes a single 10 MHz system clock; the strap level arrives already digitised
 * as an unsigned fraction of the core supply (full scale = 1.000).
 */
package ref_clock_pkg;

	// ------------------------------------------------------------
	// strap decoding (ratio in thousandths of the core supply)
	// ------------------------------------------------------------
	localparam int STRAP_W = 10;
	localparam logic [STRAP_W-1:0] PIXREF_RATIO_MIN = 10'h2ee; // 0.750
	localparam logic [STRAP_W-1:0] PIXREF_RATIO_MAX = 10'h3e8; // 1.000
	localparam logic [STRAP_W-1:0] EXTOSC_RATIO_MIN = 10'h124; // 0.292
	localparam logic [STRAP_W-1:0] EXTOSC_RATIO_MAX = 10'h153; // 0.339

	// ------------------------------------------------------------
	// clock detection timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int PIX_LOSS_TIME_NS = 1000; // no edge for this long means clock gone
	localparam int PIX_LOSS_CYCLES = (PIX_LOSS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LOSS_CNT_W = 4;

	// ------------------------------------------------------------
	// oscillator select codes and internal rates (kHz)
	// ------------------------------------------------------------
	localparam logic [1:0] OSC_SEL_LOW_A = 2'h0;
	localparam logic [1:0] OSC_SEL_HIGH = 2'h1;
	localparam logic [1:0] OSC_SEL_LOW_B = 2'h2;
	localparam logic [1:0] OSC_SEL_RSVD = 2'h3;
	localparam logic [17:0] OSC_10B_LOW_KHZ = 18'h0c350; // 50 MHz
	localparam logic [17:0] OSC_10B_HIGH_KHZ = 18'h186a0; // 100 MHz
	localparam logic [17:0] OSC_12B_LOW_KHZ = 18'h0927c; // 37.5 MHz
	localparam logic [17:0] OSC_12B_HIGH_KHZ = 18'h124f8; // 75 MHz

	// ------------------------------------------------------------
	// general-purpose pin count and frame-clock divider
	// ------------------------------------------------------------
	localparam int GP_PINS = 4;
	localparam int FRAME_DIV_10B = 2; // pixel clocks per frame clock
	localparam int FRAME_DIV_12B = 3; // two frame clocks per three pixel clocks

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_UNKNOWN = 2'h0,
		MODE_PIXREF = 2'h1,
		MODE_EXTOSC = 2'h3
	} ref_mode_type;

	typedef enum logic [1:0] {
		SRC_INTERNAL = 2'h0,
		SRC_PIXEL = 2'h1
	} link_src_type;

	typedef struct packed {
		link_src_type src;   // current link timing source
		logic [17:0] osc_khz; // internal oscillator rate in use
		logic osc_rsvd;      // reserved select code is applied
		logic frame_en;      // frame clock enable pulse
	} link_timing_type;

endpackage : ref_clock_pkg

// File: hw/ref_clock_select.sv
/*
 * reference-clock selection for a video serializer: strap decode, oscillator
 * halving for the sensor, automatic internal/pixel clock switch, pin ownership.
 * assumes one 10 MHz system clock; pixel and oscillator clocks arrive as slow
 * pins sampled on it (test rates), and the 12-bit flag and control bits come
 * from elsewhere in the serializer as plain levels.
 */
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - oscillator pin becomes clock input in oscillator mode
// - halve oscillator clock, drive second pin to sensor
// - pixel edge with control bit clear selects pixel
// - pixel clock loss returns to internal oscillator
// - clock pins do not mirror remote inputs
// - pixel-reference mode keeps all four pins free
// - strap ratio bands pick reference mode
// - select field sets internal oscillator rate
// - frame clock is pixel over two or 1.5
module ref_clock_select
(
	// system
	input wire logic clock,
	input wire logic rst_n,
	// strap and configuration
	input wire logic [ref_clock_pkg::STRAP_W-1:0] strap_ratio,
	input wire logic twelve_bit_mode,
	input wire logic pix_switch_disable, // control bit 0x03[1]
	input wire logic [1:0] osc_rate_sel, // control field 0x14[2:1]
	// clock pins
	input wire logic pixel_clock_in,
	input wire logic osc_ref_input_pin, // oscillator_clock_in when repurposed
	// general-purpose pins: remote values and local register values
	input wire logic [ref_clock_pkg::GP_PINS-1:0] remote_gp_in,
	input wire logic [ref_clock_pkg::GP_PINS-1:0] local_gp_in,
	input wire logic [ref_clock_pkg::GP_PINS-1:0] remote_sel,
	// pin drive
	output logic [ref_clock_pkg::GP_PINS-1:0] gp_out,
	output logic [ref_clock_pkg::GP_PINS-1:0] gp_oe,
	// status
	output ref_clock_pkg::ref_mode_type ref_mode,
	output ref_clock_pkg::link_timing_type link_timing
);

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	logic pix_s1_r, pix_s2_r, pix_d_r;      // pixel clock sync and previous
	logic osc_s1_r, osc_s2_r, osc_d_r;      // oscillator sync and previous
	logic pix_edge, osc_rise;

	// two stages before anything looks at the pins
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pix_s1_r <= 1'b0;
			pix_s2_r <= 1'b0;
			pix_d_r <= 1'b0;
			osc_s1_r <= 1'b0;
			osc_s2_r <= 1'b0;
			osc_d_r <= 1'b0;
		end
		else
		begin
			pix_s1_r <= pixel_clock_in;
			pix_s2_r <= pix_s1_r;
			pix_d_r <= pix_s2_r;
			osc_s1_r <= osc_ref_input_pin;
			osc_s2_r <= osc_s1_r;
			osc_d_r <= osc_s2_r;
		end
	end

	assign pix_edge = pix_s2_r ^ pix_d_r;
	// oscillator pin is only a clock input in oscillator mode
	assign osc_rise = (ref_mode == ref_clock_pkg::MODE_EXTOSC) && osc_s2_r && !osc_d_r;

	// ------------------------------------------------------------
	// strap latch
	// ------------------------------------------------------------
	ref_clock_pkg::ref_mode_type mode_r, mode_nxt;
	logic strap_done_r, strap_done_nxt;

	// decode once at the first edge after reset release, then hold
	always_comb
	begin
		mode_nxt = mode_r;
		strap_done_nxt = 1'b1;
		if (!strap_done_r)
		begin
			if (strap_ratio >= ref_clock_pkg::PIXREF_RATIO_MIN &&
				strap_ratio <= ref_clock_pkg::PIXREF_RATIO_MAX)
				mode_nxt = ref_clock_pkg::MODE_PIXREF;
			else if (strap_ratio >= ref_clock_pkg::EXTOSC_RATIO_MIN &&
				strap_ratio <= ref_clock_pkg::EXTOSC_RATIO_MAX)
				mode_nxt = ref_clock_pkg::MODE_EXTOSC;
			else
				mode_nxt = ref_clock_pkg::MODE_UNKNOWN; // out-of-band strap: no clock pins taken
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode_r <= ref_clock_pkg::MODE_UNKNOWN;
			strap_done_r <= 1'b0;
		end
		else
		begin
			mode_r <= mode_nxt;
			strap_done_r <= strap_done_nxt;
		end
	end

	assign ref_mode = mode_r;

	// ------------------------------------------------------------
	// oscillator halving for the sensor reference
	// ------------------------------------------------------------
	logic half_r, half_nxt;

	// toggle on each oscillator rising edge gives exactly half the rate
	always_comb
	begin
		half_nxt = half_r;
		if (ref_mode != ref_clock_pkg::MODE_EXTOSC)
			half_nxt = 1'b0;
		else if (osc_rise)
			half_nxt = ~half_r;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			half_r <= 1'b0;
		else
			half_r <= half_nxt;
	end

	// ------------------------------------------------------------
	// link source switch (internal oscillator vs pixel clock)
	// ------------------------------------------------------------
	ref_clock_pkg::link_src_type src_r, src_nxt;
	logic [ref_clock_pkg::LOSS_CNT_W-1:0] idle_r, idle_nxt;

	// the sensor is trusted to keep its pixel clock at the fixed ratio to the
	// oscillator nothing here measures that ratio
	always_comb
	begin
		src_nxt = src_r;
		idle_nxt = idle_r;
		if (pix_edge)
			idle_nxt = '0;
		else if (idle_r != ref_clock_pkg::LOSS_CNT_W'(ref_clock_pkg::PIX_LOSS_CYCLES))
			idle_nxt = idle_r + 1'b1;
		case (src_r)
			ref_clock_pkg::SRC_INTERNAL:
			begin
				if (pix_edge && !pix_switch_disable)
					src_nxt = ref_clock_pkg::SRC_PIXEL;
			end
			ref_clock_pkg::SRC_PIXEL:
			begin
				// gap of the loss time without an edge: clock considered removed
				if (idle_nxt == ref_clock_pkg::LOSS_CNT_W'(ref_clock_pkg::PIX_LOSS_CYCLES))
					src_nxt = ref_clock_pkg::SRC_INTERNAL;
			end
			default:
				src_nxt = ref_clock_pkg::SRC_INTERNAL;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			src_r <= ref_clock_pkg::SRC_INTERNAL;
			idle_r <= '0;
		end
		else
		begin
			src_r <= src_nxt;
			idle_r <= idle_nxt;
		end
	end

	// ------------------------------------------------------------
	// frame clock enable from the pixel clock
	// ------------------------------------------------------------
	logic [1:0] fdiv_r, fdiv_nxt;
	logic frame_en_nxt; // registered once, as link_timing.frame_en

	// 10-bit: one pulse every 2 pixel rising edges; 12-bit: two pulses per 3 rising edges
	always_comb
	begin
		fdiv_nxt = fdiv_r;
		frame_en_nxt = 1'b0;
		if (src_r == ref_clock_pkg::SRC_PIXEL && pix_s2_r && !pix_d_r)
		begin
			if (twelve_bit_mode)
			begin
				fdiv_nxt = (fdiv_r == 2'(ref_clock_pkg::FRAME_DIV_12B - 1)) ? 2'h0 : fdiv_r + 2'h1;
				frame_en_nxt = (fdiv_r != 2'h0);
			end
			else
			begin
				fdiv_nxt = (fdiv_r == 2'(ref_clock_pkg::FRAME_DIV_10B - 1)) ? 2'h0 : fdiv_r + 2'h1;
				frame_en_nxt = (fdiv_r == 2'h0);
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			fdiv_r <= 2'h0;
		else
			fdiv_r <= fdiv_nxt;
	end

	// ------------------------------------------------------------
	// internal oscillator rate and status
	// ------------------------------------------------------------
	ref_clock_pkg::link_timing_type timing_nxt, timing_r;

	always_comb
	begin
		timing_nxt.src = src_r;
		timing_nxt.frame_en = frame_en_nxt;
		timing_nxt.osc_rsvd = (osc_rate_sel == ref_clock_pkg::OSC_SEL_RSVD);
		case (osc_rate_sel)
			ref_clock_pkg::OSC_SEL_HIGH:
				timing_nxt.osc_khz = twelve_bit_mode ? ref_clock_pkg::OSC_12B_HIGH_KHZ :
					ref_clock_pkg::OSC_10B_HIGH_KHZ;
			default:
				// both low codes; the reserved code keeps the low rate so the link still runs
				timing_nxt.osc_khz = twelve_bit_mode ? ref_clock_pkg::OSC_12B_LOW_KHZ :
					ref_clock_pkg::OSC_10B_LOW_KHZ;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			timing_r <= '0;
		else
			timing_r <= timing_nxt;
	end

	assign link_timing = timing_r;

	// ------------------------------------------------------------
	// general-purpose pin ownership
	// ------------------------------------------------------------
	logic [ref_clock_pkg::GP_PINS-1:0] gp_out_nxt, gp_oe_nxt, gp_out_r, gp_oe_r;

	// outside oscillator mode each pin shows the remote input or the local register value
	always_comb
	begin
		gp_out_nxt = (remote_sel & remote_gp_in) | (~remote_sel & local_gp_in);
		gp_oe_nxt = '1;
		if (ref_mode == ref_clock_pkg::MODE_EXTOSC)
		begin
			// clock duty owns pins two and three, remote values never reach them
			gp_out_nxt[2] = half_nxt;
			gp_out_nxt[3] = 1'b0;
			gp_oe_nxt[3] = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gp_out_r <= '0;
			gp_oe_r <= '0;
		end
		else
		begin
			gp_out_r <= gp_out_nxt;
			gp_oe_r <= gp_oe_nxt;
		end
	end

	assign gp_out = gp_out_r;
	assign gp_oe = gp_oe_r;

endmodule : ref_clock_select
`default_nettype wire

// File: testbench/sensor_pixel_model.sv
/* image sensor model: drives the pixel clock pin at a bench-chosen rate.
   assumes the bench picks half_cycles to match the oscillator ratio. */
`timescale 1ns/1ps
`default_nettype none
module sensor_pixel_model
(
	// system
	input wire logic clock,
	// bench control
	input wire logic run,
	input wire logic [3:0] half_cycles,
	// pixel clock pin
	output logic pixel_clock
);
	logic [3:0] cnt_r; // cycles into this half period

	// stands low between bursts, as a stopped sensor clock would
	initial pixel_clock = 1'b0;
	initial cnt_r = 4'h1;
	always @(negedge clock)
	begin
		if (!run)
		begin
			pixel_clock <= 1'b0;
			cnt_r <= 4'h1;
		end
		else if (cnt_r >= half_cycles)
		begin
			pixel_clock <= ~pixel_clock;
			cnt_r <= 4'h1;
		end
		else
			cnt_r <= cnt_r + 4'h1;
	end
endmodule : sensor_pixel_model
`default_nettype wire

// File: testbench/ref_clock_select_properties.sv
/* port checker for ref_clock_select.
   assumes pixel period >= 6 clocks, oscillator half period 6 clocks. */
`timescale 1ns/1ps
`default_nettype none
module ref_clock_select_properties
(
	// system
	input wire logic clock,
	input wire logic rst_n,
	// inputs
	input wire logic twelve_bit_mode,
	input wire logic pix_switch_disable,
	input wire logic [1:0] osc_rate_sel,
	input wire logic pixel_clock_in,
	input wire logic osc_ref_input_pin,
	input wire logic [3:0] remote_gp_in,
	input wire logic [3:0] local_gp_in,
	input wire logic [3:0] remote_sel,
	// outputs
	input wire logic [3:0] gp_out,
	input wire logic [3:0] gp_oe,
	input wire ref_clock_pkg::ref_mode_type ref_mode,
	input wire ref_clock_pkg::link_timing_type link_timing
);
	// ------------------------------------------------------------
	// helper: cycles since the pixel pin last moved, saturating
	// ------------------------------------------------------------
	logic [4:0] idle_r;
	logic [4:0] idle_nxt;
	logic pix_d_r;
	always_comb
		idle_nxt = (pixel_clock_in != pix_d_r) ? 5'h00 : idle_r + {4'h0, idle_r != 5'h14};
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			idle_r <= 5'h00;
			pix_d_r <= 1'b0;
		end
		else
		begin
			idle_r <= idle_nxt;
			pix_d_r <= pixel_clock_in;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_strap_held: assert property (
		$past(rst_n) && $past(rst_n, 2) |-> $stable(ref_mode)) else $error("mode moved");
	a_osc_pins: assert property (
		ref_mode == ref_clock_pkg::MODE_EXTOSC |=> gp_oe[3:2] == 2'h1 && !gp_out[3])
		else $error("osc pins wrong");
	a_pix_pins: assert property (
		ref_mode == ref_clock_pkg::MODE_PIXREF |=> gp_oe == 4'hf && gp_out ==
		(($past(remote_sel) & $past(remote_gp_in)) | (~$past(remote_sel) & $past(local_gp_in))))
		else $error("pins not free");
	a_half_rise: assert property (
		ref_mode == ref_clock_pkg::MODE_EXTOSC && $rose(osc_ref_input_pin)
		|-> ##[1:4] $changed(gp_out[2])) else $error("halved clock missed");
	a_half_fall: assert property (
		ref_mode == ref_clock_pkg::MODE_EXTOSC && $fell(osc_ref_input_pin)
		|=> $stable(gp_out[2]) [*4]) else $error("halved clock moved");
	a_pix_switch: assert property (
		link_timing.src == ref_clock_pkg::SRC_INTERNAL && !pix_switch_disable &&
		$changed(pixel_clock_in) |-> ##[2:5] link_timing.src == ref_clock_pkg::SRC_PIXEL)
		else $error("no switch");
	a_switch_block: assert property (
		pix_switch_disable [*6] ##0 link_timing.src == ref_clock_pkg::SRC_INTERNAL
		|=> link_timing.src == ref_clock_pkg::SRC_INTERNAL) else $error("switch not blocked");
	a_loss_return: assert property (
		idle_r == 5'h14 |-> link_timing.src == ref_clock_pkg::SRC_INTERNAL)
		else $error("no return");
	a_osc_rate: assert property (
		1'b1 |=> link_timing.osc_rsvd == ($past(osc_rate_sel) == 2'h3) && link_timing.osc_khz ==
		($past(osc_rate_sel) == 2'h1 ? ($past(twelve_bit_mode) ? 18'h124f8 : 18'h186a0)
		: ($past(twelve_bit_mode) ? 18'h0927c : 18'h0c350))) else $error("rate wrong");
	a_frame_gap: assert property (
		link_timing.frame_en && !twelve_bit_mode |=> !link_timing.frame_en [*8])
		else $error("frame too often");
endmodule : ref_clock_select_properties

bind ref_clock_select ref_clock_select_properties chk (.clock, .rst_n, .twelve_bit_mode,
	.pix_switch_disable, .osc_rate_sel, .pixel_clock_in, .osc_ref_input_pin, .remote_gp_in,
	.local_gp_in, .remote_sel, .gp_out, .gp_oe, .ref_mode, .link_timing);
`default_nettype wire

// File: testbench/ref_clock_select_tb.sv
/* self-checking bench for ref_clock_select.
   assumes the sensor model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module ref_clock_select_tb;
	// ------------------------------------------------------------
	// stimulus, observed outputs, counters
	// ------------------------------------------------------------
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [9:0] strap_ratio = 10'h3e8;
	logic twelve_bit_mode = 1'b0;
	logic pix_switch_disable = 1'b0;
	logic [1:0] osc_rate_sel = 2'h0;
	logic osc_ref_input_pin = 1'b0;
	logic [3:0] remote_gp_in = 4'h5;
	logic [3:0] local_gp_in = 4'h3;
	logic [3:0] remote_sel = 4'hc;
	logic pix_run = 1'b0;
	logic [3:0] pix_half = 4'h3; // pixel half period in clocks
	wire logic pixel_clock_in;
	logic [3:0] gp_out;
	logic [3:0] gp_oe;
	ref_clock_pkg::ref_mode_type ref_mode;
	ref_clock_pkg::link_timing_type link_timing;
	int err_total = 0;
	int check_count = 0;

	initial forever #50 clock = ~clock;

	ref_clock_select uut (.clock, .rst_n, .strap_ratio, .twelve_bit_mode, .pix_switch_disable,
		.osc_rate_sel, .pixel_clock_in, .osc_ref_input_pin, .remote_gp_in, .local_gp_in,
		.remote_sel, .gp_out, .gp_oe, .ref_mode, .link_timing);
	sensor_pixel_model sensor (.clock, .run(pix_run), .half_cycles(pix_half),
		.pixel_clock(pixel_clock_in));

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [17:0] seen, input logic [17:0] want);
		check_count++;
		if (seen !== want)
		begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check

	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done

	// reset for 8 cycles with a new strap, inputs move on falling edges
	task automatic start(input logic [9:0] strap);
		@(negedge clock);
		rst_n = 1'b0;
		strap_ratio = strap;
		repeat (8) @(negedge clock);
		rst_n = 1'b1;
		repeat (3) @(negedge clock);
	endtask : start

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	// band edges, just below the pixel band and just above the oscillator band; a later strap change is ignored
	task automatic t_strap;
		logic [9:0] straps [6] = '{10'h3e8, 10'h2ee, 10'h153, 10'h124, 10'h2ed, 10'h154};
		logic [1:0] modes [6] = '{2'h1, 2'h1, 2'h3, 2'h3, 2'h0, 2'h0};
		for (int i = 0; i < 6; i++)
		begin
			start(straps[i]);
			check(ref_mode, modes[i]);
			check(gp_oe, modes[i] == 2'h3 ? 4'h7 : 4'hf);
			if (modes[i] != 2'h3)
				check(gp_out, 4'h7);
			strap_ratio = straps[(i + 2) % 6];
			repeat (3) @(negedge clock);
			check(ref_mode, modes[i]);
		end
	endtask : t_strap

	// oscillator halved onto the second pin while remote values churn, both payload modes
	task automatic t_osc;
		int flips;
		logic last;
		start(10'h124);
		remote_sel = 4'hf;
		for (int m = 0; m < 2; m++)
		begin
			twelve_bit_mode = m[0];
			pix_half = m[0] ? 4'h4 : 4'h3; // pixel 1.5x or 2x the oscillator
			pix_run = 1'b1;
			flips = 0;
			last = gp_out[2];
			for (int i = 0; i < 100; i++)
			begin
				@(negedge clock);
				osc_ref_input_pin = (i % 12) >= 6 && i < 96;
				remote_gp_in = ~remote_gp_in;
				flips += (gp_out[2] !== last);
				last = gp_out[2];
			end
			check(flips, 8);
			check(gp_oe[3:2], 2'h1);
			check(gp_out[3], 1'b0);
			// let the pixel clock be lost before the payload mode moves
			pix_run = 1'b0;
			repeat (16) @(negedge clock);
		end
		twelve_bit_mode = 1'b0;
		pix_half = 4'h3;
		remote_sel = 4'hc;
	endtask : t_osc

	// switch to pixel clock, frame pulses, loss, and the blocking bit
	task automatic t_switch;
		int pulses;
		start(10'h3e8);
		for (int m = 0; m < 2; m++)
		begin
			twelve_bit_mode = m[0];
			pix_run = 1'b1;
			repeat (20) @(negedge clock);
			check(link_timing.src, ref_clock_pkg::SRC_PIXEL);
			pulses = 0;
			repeat (72)
			begin
				@(negedge clock);
				pulses += (link_timing.frame_en === 1'b1);
			end
			check(pulses, m ? 8 : 6);
			pix_run = 1'b0;
			repeat (24) @(negedge clock);
			check(link_timing.src, ref_clock_pkg::SRC_INTERNAL);
		end
		pix_switch_disable = 1'b1;
		pix_run = 1'b1;
		repeat (30) @(negedge clock);
		check(link_timing.src, ref_clock_pkg::SRC_INTERNAL);
		pix_run = 1'b0;
		repeat (24) @(negedge clock);
		pix_switch_disable = 1'b0;
		twelve_bit_mode = 1'b0;
	endtask : t_switch

	// every select code in both payload modes
	task automatic t_rate;
		for (int k = 0; k < 8; k++)
		begin
			twelve_bit_mode = k[2];
			osc_rate_sel = k[1:0];
			repeat (2) @(negedge clock);
			check(link_timing.osc_khz, k[1:0] == 2'h1 ? (k[2] ? 18'h124f8 : 18'h186a0)
				: (k[2] ? 18'h0927c : 18'h0c350));
			check(link_timing.osc_rsvd, k[1:0] == 2'h3);
		end
	endtask : t_rate

	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial
	begin
		t_strap();
		t_osc();
		t_switch();
		t_rate();
		test_done();
	end

	initial
	begin
		#2000000;
		err_total++;
		test_done();
	end
endmodule : ref_clock_select_tb
`default_nettype wire
